// ### hdl/isb_pkg.sv
// constants and carrier types for the interpolated set-point buffer
package isb_pkg;

    // object dictionary indices
    localparam logic [15:0] IDX_TORQUE_BIAS = 16'h60b2;
    localparam logic [15:0] IDX_DATA_RECORD = 16'h60c1;
    localparam logic [15:0] IDX_TIME_PERIOD = 16'h60c2;
    localparam logic [15:0] IDX_DATA_CONFIG = 16'h60c4;

    // subindices
    localparam logic [7:0] SUB_ENTRIES = 8'h00;
    localparam logic [7:0] SUB_FIRST_POS = 8'h01;
    localparam logic [7:0] SUB_PERIOD_VALUE = 8'h01;
    localparam logic [7:0] SUB_PERIOD_EXP = 8'h02;
    localparam logic [7:0] SUB_MAX_CAPACITY = 8'h01;
    localparam logic [7:0] SUB_RECORD_COUNT = 8'h02;
    localparam logic [7:0] SUB_LAYOUT = 8'h03;
    localparam logic [7:0] SUB_NEXT_FREE = 8'h04;
    localparam logic [7:0] SUB_RECORD_SIZE = 8'h05;
    localparam logic [7:0] SUB_FLUSH = 8'h06;

    // number-of-entries answers
    localparam logic [7:0] RECORD_ENTRIES = 8'h01;
    localparam logic [7:0] PERIOD_ENTRIES = 8'h02;
    localparam logic [7:0] CONFIG_ENTRIES = 8'h06;

    // reset values
    localparam logic [15:0] RST_TORQUE_BIAS = 16'h0000;
    localparam logic [31:0] RST_FIRST_POS = 32'h0000_0000;
    localparam logic [7:0] RST_PERIOD_VALUE = 8'h01;
    localparam logic [7:0] RST_PERIOD_EXP = 8'hfd;
    localparam logic [31:0] RST_RECORD_COUNT = 32'h0000_0001;
    localparam logic [7:0] RST_LAYOUT = 8'h00;
    localparam logic [15:0] RST_NEXT_FREE = 16'h0001;
    localparam logic [7:0] RST_RECORD_SIZE = 8'h04;

    // field codes
    localparam logic [7:0] LAYOUT_FIFO = 8'h00;
    localparam logic [7:0] LAYOUT_RING = 8'h01;
    localparam logic [7:0] FLUSH_ALL = 8'h00;
    localparam logic [7:0] ACCESS_ON = 8'h01;

    // object dictionary request, one cycle wide
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } isb_od_req_t;

    // answer, registered, valid one cycle after the request
    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] data;
    } isb_od_rsp_t;

endpackage

// ### hdl/isb_setpoint_buffer.sv
// interpolated set-point buffer: record fifo and object dictionary front end
// Functional notes
// - torque bias is signed 16 bit, tenths of percent, added to torque demand
// - bias applies only in cyclic position, cyclic torque and step/direction modes
// - first set-point entry is a signed 32-bit demand position for interpolation
// - a written set-point takes effect only at the next sync pulse
// - cycle time equals period value times ten to the exponent; value defaults one; exponents outside -6..-1 give zero cycle time and a fault
// - maximum record capacity reads back read-only, default one record
// - keep a 32-bit count of records in the buffer, default one
// - layout select 00 means fifo, 01 means ring buffer; fifo by default
// - keep 16-bit index of the next free buffer entry, default one
// - write-only record size counts bytes per record, default four
// - flush code 00 discards buffered data and records, disables access
// - flush code 01 enables access to the input buffer
`timescale 1ns/1ps

module isb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic push;
    logic pop;

    // a full fifo still takes a word while one leaves, so recirculation works
    assign out_valid = (level != '0);
    assign in_ready = (level != (AW+1)'(DEPTH)) || out_ready;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage, no reset needed on data
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
        end
        else if (flush)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    // fill level
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            level <= '0;
        end
        else if (flush)
        begin
            level <= '0;
        end
        else if (push && !pop)
        begin
            level <= level + 1'b1;
        end
        else if (pop && !push)
        begin
            level <= level - 1'b1;
        end
    end
endmodule

module isb_setpoint_buffer #(
    parameter int DEPTH = 32,
    parameter logic [31:0] CAPACITY = 32'h0000_0001,
    parameter logic [7:0] MODE_CSP = 8'h08,
    parameter logic [7:0] MODE_CST = 8'h0a,
    parameter logic [7:0] MODE_STEP_DIR = 8'hff
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire isb_pkg::isb_od_req_t od_req,
    output isb_pkg::isb_od_rsp_t od_rsp,
    input wire logic sync_pulse,
    input wire logic [7:0] op_mode,
    input wire logic signed [15:0] torque_demand,
    output logic signed [15:0] torque_cmd,
    output logic signed [31:0] demand_position,
    output logic demand_strobe,
    output logic setpoint_ready,
    output logic access_enabled,
    output logic [31:0] interp_cycle_us,
    output logic period_fault,
    output logic [7:0] record_size_bytes
);
    localparam int LW = $clog2(DEPTH) + 1;

    logic signed [15:0] torque_setpoint_bias;
    logic [7:0] interp_period_value;
    logic [7:0] interp_period_exponent;
    logic [31:0] current_record_count;
    logic [7:0] buffer_layout_select;
    logic [15:0] next_free_slot;
    logic [LW-1:0] fifo_level;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;
    logic hit_pos;
    logic host_push;
    logic recirc;
    logic pop;
    logic flush;
    logic ring;
    logic room;
    logic bias_mode;
    logic signed [16:0] torque_sum;
    logic [31:0] next_cycle_us;
    logic next_fault;
    logic next_err;
    logic [31:0] next_rdata;

    // request decode
    assign ring = (buffer_layout_select == isb_pkg::LAYOUT_RING);
    assign flush = od_req.wr && (od_req.index == isb_pkg::IDX_DATA_CONFIG)
        && (od_req.sub == isb_pkg::SUB_FLUSH) && (od_req.data[7:0] == isb_pkg::FLUSH_ALL);
    assign hit_pos = od_req.wr && (od_req.index == isb_pkg::IDX_DATA_RECORD)
        && (od_req.sub == isb_pkg::SUB_FIRST_POS);
    assign room = ({{(32-LW){1'b0}}, fifo_level} < CAPACITY);
    // sync drains one record; ring layout puts it straight back in the tail
    assign pop = sync_pulse && fifo_out_valid && !flush;
    assign recirc = pop && ring;
    // host writes blocked while disabled, full, or losing to recirculation
    assign setpoint_ready = access_enabled && fifo_in_ready && room && !recirc;
    assign host_push = hit_pos && setpoint_ready;

    isb_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .flush(flush),
        .in_valid(host_push || recirc),
        .in_ready(fifo_in_ready),
        .in_data(recirc ? fifo_out_data : od_req.data),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // applied demand position, updated only on sync
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            demand_position <= isb_pkg::RST_FIRST_POS;
            demand_strobe <= 1'b0;
        end
        else
        begin
            demand_strobe <= pop;
            if (pop)
            begin
                demand_position <= fifo_out_data;
            end
        end
    end

    // buffer access enable; off after reset until the host opens it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            access_enabled <= 1'b0;
        end
        else if (flush)
        begin
            access_enabled <= 1'b0;
        end
        else if (od_req.wr && (od_req.index == isb_pkg::IDX_DATA_CONFIG)
            && (od_req.sub == isb_pkg::SUB_FLUSH) && (od_req.data[7:0] == isb_pkg::ACCESS_ON))
        begin
            access_enabled <= 1'b1;
        end
    end

    // record count: host write sets it, pushes and fifo pops move it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            current_record_count <= isb_pkg::RST_RECORD_COUNT;
        end
        else if (flush)
        begin
            current_record_count <= '0;
        end
        else if (od_req.wr && (od_req.index == isb_pkg::IDX_DATA_CONFIG)
            && (od_req.sub == isb_pkg::SUB_RECORD_COUNT))
        begin
            current_record_count <= od_req.data;
        end
        else if (host_push)
        begin
            current_record_count <= current_record_count + 32'h0000_0001;
        end
        else if (pop && !ring && (current_record_count != '0))
        begin
            current_record_count <= current_record_count - 32'h0000_0001;
        end
    end

    // next free slot, 1-based, wraps back to 1 past capacity
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            next_free_slot <= isb_pkg::RST_NEXT_FREE;
        end
        else if (flush)
        begin
            next_free_slot <= isb_pkg::RST_NEXT_FREE;
        end
        else if (od_req.wr && (od_req.index == isb_pkg::IDX_DATA_CONFIG)
            && (od_req.sub == isb_pkg::SUB_NEXT_FREE))
        begin
            next_free_slot <= od_req.data[15:0];
        end
        else if (host_push)
        begin
            next_free_slot <= (next_free_slot >= CAPACITY[15:0])
                ? isb_pkg::RST_NEXT_FREE : next_free_slot + 16'h0001;
        end
    end

    // plain configuration objects
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            torque_setpoint_bias <= isb_pkg::RST_TORQUE_BIAS;
            interp_period_value <= isb_pkg::RST_PERIOD_VALUE;
            interp_period_exponent <= isb_pkg::RST_PERIOD_EXP;
            buffer_layout_select <= isb_pkg::RST_LAYOUT;
            record_size_bytes <= isb_pkg::RST_RECORD_SIZE;
        end
        else if (od_req.wr)
        begin
            if (od_req.index == isb_pkg::IDX_TORQUE_BIAS)
            begin
                torque_setpoint_bias <= od_req.data[15:0];
            end
            if (od_req.index == isb_pkg::IDX_TIME_PERIOD)
            begin
                if (od_req.sub == isb_pkg::SUB_PERIOD_VALUE)
                begin
                    interp_period_value <= od_req.data[7:0];
                end
                if (od_req.sub == isb_pkg::SUB_PERIOD_EXP)
                begin
                    interp_period_exponent <= od_req.data[7:0];
                end
            end
            if (od_req.index == isb_pkg::IDX_DATA_CONFIG)
            begin
                if (od_req.sub == isb_pkg::SUB_LAYOUT)
                begin
                    buffer_layout_select <= od_req.data[7:0];
                end
                if (od_req.sub == isb_pkg::SUB_RECORD_SIZE)
                begin
                    record_size_bytes <= od_req.data[7:0];
                end
            end
        end
    end

    // cycle time in microseconds; exponents outside -6..-1 flag a fault
    always_comb
    begin
        next_fault = 1'b0;
        case (interp_period_exponent)
            8'hfa: next_cycle_us = {24'h00_0000, interp_period_value};
            8'hfb: next_cycle_us = {24'h00_0000, interp_period_value} * 32'h0000_000a;
            8'hfc: next_cycle_us = {24'h00_0000, interp_period_value} * 32'h0000_0064;
            8'hfd: next_cycle_us = {24'h00_0000, interp_period_value} * 32'h0000_03e8;
            8'hfe: next_cycle_us = {24'h00_0000, interp_period_value} * 32'h0000_2710;
            8'hff: next_cycle_us = {24'h00_0000, interp_period_value} * 32'h0001_86a0;
            default:
            begin
                next_cycle_us = '0;
                next_fault = 1'b1;
            end
        endcase
    end

    // torque bias only in the three cyclic/step modes, saturated at 16 bit
    assign bias_mode = (op_mode == MODE_CSP) || (op_mode == MODE_CST)
        || (op_mode == MODE_STEP_DIR);
    assign torque_sum = {torque_demand[15], torque_demand}
        + {torque_setpoint_bias[15], torque_setpoint_bias};

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            torque_cmd <= '0;
            interp_cycle_us <= '0;
            period_fault <= 1'b0;
        end
        else
        begin
            interp_cycle_us <= next_cycle_us;
            period_fault <= next_fault;
            if (!bias_mode)
            begin
                torque_cmd <= torque_demand;
            end
            else if (torque_sum[16] != torque_sum[15])
            begin
                torque_cmd <= torque_sum[16] ? 16'sh8000 : 16'sh7fff;
            end
            else
            begin
                torque_cmd <= torque_sum[15:0];
            end
        end
    end

    // answer mux; write-only reads, read-only writes and refused pushes abort
    always_comb
    begin
        next_err = 1'b0;
        next_rdata = '0;
        case (od_req.index)
            isb_pkg::IDX_TORQUE_BIAS:
            begin
                next_err = (od_req.sub != isb_pkg::SUB_ENTRIES);
                next_rdata = {{16{torque_setpoint_bias[15]}}, torque_setpoint_bias};
            end
            isb_pkg::IDX_DATA_RECORD:
            begin
                if (od_req.sub == isb_pkg::SUB_ENTRIES)
                begin
                    next_err = od_req.wr;
                    next_rdata = {24'h00_0000, isb_pkg::RECORD_ENTRIES};
                end
                else if (od_req.sub == isb_pkg::SUB_FIRST_POS)
                begin
                    next_err = od_req.wr && !setpoint_ready;
                    next_rdata = demand_position;
                end
                else
                begin
                    next_err = 1'b1;
                end
            end
            isb_pkg::IDX_TIME_PERIOD:
            begin
                case (od_req.sub)
                    isb_pkg::SUB_ENTRIES:
                    begin
                        next_err = od_req.wr;
                        next_rdata = {24'h00_0000, isb_pkg::PERIOD_ENTRIES};
                    end
                    isb_pkg::SUB_PERIOD_VALUE: next_rdata = {24'h00_0000, interp_period_value};
                    isb_pkg::SUB_PERIOD_EXP:
                        next_rdata = {{24{interp_period_exponent[7]}}, interp_period_exponent};
                    default: next_err = 1'b1;
                endcase
            end
            isb_pkg::IDX_DATA_CONFIG:
            begin
                case (od_req.sub)
                    isb_pkg::SUB_ENTRIES:
                    begin
                        next_err = od_req.wr;
                        next_rdata = {24'h00_0000, isb_pkg::CONFIG_ENTRIES};
                    end
                    isb_pkg::SUB_MAX_CAPACITY:
                    begin
                        next_err = od_req.wr;
                        next_rdata = CAPACITY;
                    end
                    isb_pkg::SUB_RECORD_COUNT: next_rdata = current_record_count;
                    isb_pkg::SUB_LAYOUT: next_rdata = {24'h00_0000, buffer_layout_select};
                    isb_pkg::SUB_NEXT_FREE: next_rdata = {16'h0000, next_free_slot};
                    isb_pkg::SUB_RECORD_SIZE: next_err = od_req.rd;
                    isb_pkg::SUB_FLUSH: next_err = od_req.rd;
                    default: next_err = 1'b1;
                endcase
            end
            default: next_err = 1'b1;
        endcase
    end

    // one answer per request, one cycle later
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            od_rsp <= '0;
        end
        else
        begin
            od_rsp.valid <= od_req.wr || od_req.rd;
            od_rsp.err <= (od_req.wr || od_req.rd) && next_err;
            od_rsp.data <= (od_req.rd && !next_err) ? next_rdata : '0;
        end
    end
endmodule

// ### sim/isb_props.sv
// concurrent checks on the set-point buffer ports
`timescale 1ns/1ps

module isb_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire isb_pkg::isb_od_req_t od_req,
    input wire isb_pkg::isb_od_rsp_t od_rsp,
    input wire logic sync_pulse,
    input wire logic [7:0] op_mode,
    input wire logic signed [15:0] torque_demand,
    input wire logic signed [15:0] torque_cmd,
    input wire logic signed [31:0] demand_position,
    input wire logic demand_strobe,
    input wire logic setpoint_ready,
    input wire logic access_enabled,
    input wire logic [7:0] record_size_bytes
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // one dictionary write, matched on index and subindex
    sequence s_wr(logic [15:0] idx, logic [7:0] s);
        od_req.wr && od_req.index == idx && od_req.sub == s;
    endsequence
    sequence s_cfg(logic [7:0] s, logic [7:0] v);
        s_wr(isb_pkg::IDX_DATA_CONFIG, s) ##0 od_req.data[7:0] == v;
    endsequence

    // first edge after reset still sees reset-time demand
    property p_no_bias;
        !$past(rst) && op_mode != 8'h08 && op_mode != 8'h0a && op_mode != 8'hff
            |=> torque_cmd == $past(torque_demand);
    endproperty
    a_no_bias: assert property (p_no_bias) else $error("torque offset outside mode");
    property p_strobe_sync;
        demand_strobe |-> $past(sync_pulse);
    endproperty
    a_strobe_sync: assert property (p_strobe_sync) else $error("strobe without sync");
    property p_pos_sync;
        $changed(demand_position) |-> $past(sync_pulse);
    endproperty
    a_pos_sync: assert property (p_pos_sync) else $error("position moved without sync");
    property p_enable;
        s_cfg(isb_pkg::SUB_FLUSH, isb_pkg::ACCESS_ON) |=> access_enabled;
    endproperty
    a_enable: assert property (p_enable) else $error("access not enabled");
    property p_flush;
        s_cfg(isb_pkg::SUB_FLUSH, isb_pkg::FLUSH_ALL) |=> !access_enabled && !setpoint_ready;
    endproperty
    a_flush: assert property (p_flush) else $error("access left on after flush");
    property p_off_ready;
        !access_enabled |-> !setpoint_ready;
    endproperty
    a_off_ready: assert property (p_off_ready) else $error("ready while access off");
    property p_refuse;
        s_wr(isb_pkg::IDX_DATA_RECORD, isb_pkg::SUB_FIRST_POS) ##0 !setpoint_ready
            |=> od_rsp.valid && od_rsp.err;
    endproperty
    a_refuse: assert property (p_refuse) else $error("set-point write not refused");
    property p_rec_size;
        s_wr(isb_pkg::IDX_DATA_CONFIG, isb_pkg::SUB_RECORD_SIZE)
            |=> record_size_bytes == $past(od_req.data[7:0]);
    endproperty
    a_rec_size: assert property (p_rec_size) else $error("record size not taken");
    property p_cap_ro;
        s_wr(isb_pkg::IDX_DATA_CONFIG, isb_pkg::SUB_MAX_CAPACITY) |=> od_rsp.err;
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capacity write accepted");
    property p_pos_read;
        od_req.rd && od_req.index == isb_pkg::IDX_DATA_RECORD && od_req.sub == 8'h01
            |=> od_rsp.valid && od_rsp.data == $past(demand_position);
    endproperty
    a_pos_read: assert property (p_pos_read) else $error("position read wrong");
endmodule

// ### sim/isb_host_model.sv
// host master model driving the object dictionary port
`timescale 1ns/1ps

module isb_host_model (
    input wire logic ref_clk,
    output isb_pkg::isb_od_req_t od_req,
    input wire isb_pkg::isb_od_rsp_t od_rsp
);
    initial od_req = '0;

    // one-cycle request; idle lines carry inverted values
    task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, output logic e, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        od_req <= '{w, !w, i, s, d};
        @(posedge ref_clk);
        od_req <= '{1'b0, 1'b0, ~i, ~s, ~d};
        #1;
        while (od_rsp.valid !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        e = (n < 4) ? od_rsp.err : 1'bx;
        q = od_rsp.data;
    endtask

    // millisecond time base, exponent fd, which is also the reset value
    task automatic set_ms_base(output logic e);
        logic [31:0] q;
        access(1'b1, isb_pkg::IDX_TIME_PERIOD, isb_pkg::SUB_PERIOD_EXP, 32'hfd, e, q);
    endtask
endmodule

// ### sim/test_interpolated_setpoint_buffer.sv
// self-checking bench for the interpolated set-point buffer
`timescale 1ns/1ps

module test_interpolated_setpoint_buffer;
    typedef struct packed {
        logic w;
        logic [15:0] i;
        logic [7:0] s;
        logic [31:0] d;
        logic e;
        logic [31:0] q;
    } isb_row_t;
    localparam isb_row_t ROWS[22] = '{
        '{1'b0, 16'h60b2, 8'h00, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h60c1, 8'h00, 32'h0, 1'b0, 32'h1},
        '{1'b0, 16'h60c1, 8'h01, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h60c2, 8'h01, 32'h0, 1'b0, 32'h1},
        '{1'b0, 16'h60c2, 8'h02, 32'h0, 1'b0, 32'hffff_fffd},
        '{1'b0, 16'h60c4, 8'h01, 32'h0, 1'b0, 32'h1},
        '{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h1},
        '{1'b0, 16'h60c4, 8'h03, 32'h0, 1'b0, 32'h0},
        '{1'b0, 16'h60c4, 8'h04, 32'h0, 1'b0, 32'h1},
        '{1'b1, 16'h60c4, 8'h01, 32'h5, 1'b1, 32'h0},
        '{1'b0, 16'h60c4, 8'h05, 32'h0, 1'b1, 32'h0},
        '{1'b0, 16'h60c4, 8'h06, 32'h0, 1'b1, 32'h0},
        '{1'b1, 16'h60c1, 8'h01, 32'h1234, 1'b1, 32'h0},
        '{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h1},
        '{1'b1, 16'h60b2, 8'h00, 32'hff9c, 1'b0, 32'h0},
        '{1'b0, 16'h60b2, 8'h00, 32'h0, 1'b0, 32'hffff_ff9c},
        '{1'b1, 16'h60c4, 8'h05, 32'h8, 1'b0, 32'h0},
        '{1'b1, 16'h60c4, 8'h03, 32'h1, 1'b0, 32'h0},
        '{1'b0, 16'h60c4, 8'h03, 32'h0, 1'b0, 32'h1},
        '{1'b1, 16'h60c4, 8'h03, 32'h0, 1'b0, 32'h0},
        '{1'b1, 16'h60c4, 8'h02, 32'h5, 1'b0, 32'h0},
        '{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h5}
    };
    localparam logic [7:0] MODES[5] = '{8'h08, 8'h0a, 8'hff, 8'h01, 8'h06};
    localparam logic [4:0] BIASED = 5'h07;
    logic ref_clk;
    logic rst;
    logic sync_pulse;
    logic [7:0] op_mode;
    logic signed [15:0] torque_demand;
    logic signed [15:0] torque_cmd;
    logic signed [31:0] demand_position;
    logic demand_strobe;
    logic setpoint_ready;
    logic access_enabled;
    logic [31:0] interp_cycle_us;
    logic period_fault;
    logic [7:0] record_size_bytes;
    logic e;
    isb_pkg::isb_od_req_t od_req;
    isb_pkg::isb_od_rsp_t od_rsp;
    int num_errors = 0;
    int num_checks = 0;

    isb_setpoint_buffer u_dut (.*);
    isb_host_model u_host (.*);

    // free-running 50 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    // one access, answer held against the row
    task automatic od(input isb_row_t r);
        logic re;
        logic [31:0] q;
        u_host.access(r.w, r.i, r.s, r.d, re, q);
        chk($sformatf("err %h:%h", r.i, r.s), {31'h0, r.e}, {31'h0, re});
        chk($sformatf("data %h:%h", r.i, r.s), r.q, q);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // one sync pulse; strobe seen the cycle after
    task automatic sync(input logic exp_strobe);
        @(posedge ref_clk);
        sync_pulse <= 1'b1;
        @(posedge ref_clk);
        sync_pulse <= 1'b0;
        #1;
        chk("strobe", {31'h0, exp_strobe}, {31'h0, demand_strobe});
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // run is well under two hundred cycles; this ends a hang
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        rst = 1'b1;
        sync_pulse = 1'b0;
        op_mode = 8'h00;
        torque_demand = 16'h0000;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (ROWS[k])
            od(ROWS[k]);
        $display("table test done");
        // size output, cycle time and exponent range
        chk("size", 32'h8, {24'h0, record_size_bytes});
        chk("cycle", 32'h03e8, interp_cycle_us);
        od('{1'b1, 16'h60c2, 8'h01, 32'h5, 1'b0, 32'h0});
        od('{1'b1, 16'h60c2, 8'h02, 32'hfc, 1'b0, 32'h0});
        step(2);
        chk("cycle", 32'h01f4, interp_cycle_us);
        u_host.set_ms_base(e);
        chk("ms base", 32'h0, {31'h0, e});
        step(2);
        chk("cycle", 32'h1388, interp_cycle_us);
        od('{1'b1, 16'h60c2, 8'h02, 32'h0, 1'b0, 32'h0});
        step(2);
        chk("fault", 32'h1, {31'h0, period_fault});
        u_host.set_ms_base(e);
        $display("period test done");
        // bias of -100 only in the three offset modes
        @(posedge ref_clk);
        torque_demand <= 16'h00c8;
        for (int k = 0; k < 5; k++)
        begin
            @(posedge ref_clk);
            op_mode <= MODES[k];
            step(2);
            chk("torque", BIASED[k] ? 32'h64 : 32'hc8, {16'h0, torque_cmd});
        end
        $display("torque test done");
        // fifo: enable, push, refuse at capacity, apply on sync
        od('{1'b1, 16'h60c4, 8'h06, 32'h1, 1'b0, 32'h0});
        chk("ready", 32'h1, {31'h0, setpoint_ready});
        od('{1'b1, 16'h60c1, 8'h01, 32'h1234, 1'b0, 32'h0});
        od('{1'b1, 16'h60c1, 8'h01, 32'h4321, 1'b1, 32'h0});
        od('{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h6});
        od('{1'b0, 16'h60c4, 8'h04, 32'h0, 1'b0, 32'h1});
        od('{1'b0, 16'h60c1, 8'h01, 32'h0, 1'b0, 32'h0});
        sync(1'b1);
        od('{1'b0, 16'h60c1, 8'h01, 32'h0, 1'b0, 32'h1234});
        od('{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h5});
        $display("fifo test done");
        // ring: popped record goes back, count holds
        od('{1'b1, 16'h60c4, 8'h03, 32'h1, 1'b0, 32'h0});
        od('{1'b1, 16'h60c1, 8'h01, 32'h5678, 1'b0, 32'h0});
        sync(1'b1);
        sync(1'b1);
        chk("position", 32'h5678, demand_position);
        od('{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h6});
        $display("ring test done");
        // flush empties everything and locks writes out
        od('{1'b1, 16'h60c4, 8'h06, 32'h0, 1'b0, 32'h0});
        chk("access", 32'h0, {31'h0, access_enabled});
        od('{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h0});
        sync(1'b0);
        od('{1'b1, 16'h60c1, 8'h01, 32'h9, 1'b1, 32'h0});
        od('{1'b0, 16'h60c4, 8'h04, 32'h0, 1'b0, 32'h1});
        $display("flush test done");
        // second reset in mid-run
        @(posedge ref_clk);
        rst <= 1'b1;
        step(3);
        @(posedge ref_clk);
        rst <= 1'b0;
        od('{1'b0, 16'h60c4, 8'h02, 32'h0, 1'b0, 32'h1});
        chk("size", 32'h4, {24'h0, record_size_bytes});
        $display("reset test done");
        print_verdict();
    end
endmodule

bind isb_setpoint_buffer isb_props u_props (
    .ref_clk(ref_clk), .rst(rst), .od_req(od_req), .od_rsp(od_rsp),
    .sync_pulse(sync_pulse), .op_mode(op_mode), .torque_demand(torque_demand),
    .torque_cmd(torque_cmd), .demand_position(demand_position),
    .demand_strobe(demand_strobe), .setpoint_ready(setpoint_ready),
    .access_enabled(access_enabled), .record_size_bytes(record_size_bytes)
);
